/* verilog/temp_monitor_regs.sv */
// Result, status and configuration registers of a four-channel
// temperature monitor, with alert and over-temperature outputs.
// Assumes a bus protocol engine issuing one-cycle byte read and write
// strobes, and a converter supplying results and live limit conditions.
`timescale 1ns/100ps

// Overview of operation
// - Internal fraction sits in low byte bits 7..5, eighth degree steps.
// - Unimplemented bits, low-byte bits 4..0, rate bits 6..4 read zero.
// - Each external channel high byte holds two's complement integer.
// - External fractions sit in low byte bits 7..5, same code.
// - Status bit 7 follows converter busy and never drives alert or over-temperature output.
// - Status bit 6 sets on internal above-high; asserts alert.
// - Status bit 5 sets on internal below-low; asserts alert.
// - Bits 4 and 3 set on external high/low; assert alert.
// - Bit 2 sets on diode open or short; asserts alert.
// - Bits 1,0 track over-temperature; clear when that output releases.
// - Mask bit blocks alert in interrupt mode only; flags still update.
// - Config bit 6 selects standby, else continuous conversion.
// - Config bit 5 selects comparator alert mode, ignoring mask.
// - Config bit 4 turns off resistance correction for channel 1.
// - Config bit 3 turns off resistance correction for channels 2, 3.
// - Config bit 2 selects extended offset-binary range.
// - Config bit 1 turns off dynamic averaging.
// - Config bit 0 measures a single diode on second pair.
// - Both configuration addresses reach one physical register.
// - Rate register aliased twice; bit 7 sleep, code resets 0110.
// - Sleep bit overrides standby select; else standby bit decides.
// - High-byte read latches low byte shadow; low reads return it.
// - One-shot write converts only in standby and not busy.
module temp_monitor_regs (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire temp_regs_pkg::addr_t reg_addr,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire temp_regs_pkg::byte_t reg_wdata,
   output logic [7:0]                reg_rdata,
   input  wire logic                 adc_busy,
   input  wire logic                 result_valid,
   input  wire temp_regs_pkg::chan_t result_channel,
   input  wire temp_regs_pkg::byte_t result_integer,
   input  wire temp_regs_pkg::frac_t result_fraction,
   input  wire logic                 int_high_cond,
   input  wire logic                 int_low_cond,
   input  wire logic                 ext_high_cond,
   input  wire logic                 ext_low_cond,
   input  wire logic                 diode_fault_cond,
   input  wire logic                 ext_therm_cond,
   input  wire logic                 int_therm_cond,
   output logic                      alert_out,
   output logic                      therm_out,
   output logic                      conversion_enable,
   output logic                      single_conversion_trigger,
   output logic                      standby_mode,
   output logic                      sleep_mode,
   output logic                      resistance_corr_off_ch1,
   output logic                      resistance_corr_off_ch23,
   output logic                      range_extended,
   output logic                      averaging_disable,
   output logic                      antiparallel_disable,
   output logic [3:0]                rate_code
);
   import temp_regs_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      byte_t              cfg;
      byte_t              rate;
      byte_t              status;
      logic [3:0][7:0]    integ;
      logic [3:0][2:0]    frac;
      logic [3:0][2:0]    shadow;
      byte_t              rdata;
      logic               alert;
      logic               therm;
      logic               trigger;
      op_mode_t           mode;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ==========================================================
   // Address decode helpers
   function automatic logic is_config(input addr_t a);
      return (a == CONFIG_ADDR) || (a == CONFIG_ALIAS_ADDR);
   endfunction

   function automatic logic is_rate(input addr_t a);
      return (a == RATE_ADDR) || (a == RATE_ALIAS_ADDR);
   endfunction

   // Places a three-bit fraction in bits 7..5, zero below
   function automatic byte_t frac_byte(input frac_t f);
      return {f, 5'b00000};
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic        status_rd;
      logic        therm_d;
      logic [4:0]  alert_flags;
      status_rd   = 1'b0;
      therm_d     = 1'b0;
      alert_flags = 5'b00000;
      s_d         = s_q;
      s_d.trigger = 1'b0;

      // Results from the converter, stored per channel
      if (result_valid) begin
         s_d.integ[result_channel] = result_integer;
         s_d.frac[result_channel]  = result_fraction;
      end

      // Register writes; aliases share one storage
      if (reg_wr) begin
         if (is_config(reg_addr)) begin
            s_d.cfg = reg_wdata;
         end else if (is_rate(reg_addr)) begin
            s_d.rate = reg_wdata & RATE_WR_MASK;
         end else if (reg_addr == ONE_SHOT_ADDR) begin
            // Ignored when active, asleep or busy
            s_d.trigger = (s_q.mode == MODE_STANDBY) && !adc_busy;
         end
      end

      // Register reads, answered one cycle later from a flop
      s_d.rdata = s_q.rdata;
      if (reg_rd) begin
         if (reg_addr == INT_INTEGER_ADDR) begin
            s_d.rdata = s_q.integ[CH_INT];
            s_d.shadow[CH_INT] = s_q.frac[CH_INT];
         end else if (reg_addr == EXT1_INTEGER_ADDR) begin
            s_d.rdata = s_q.integ[CH_EXT1];
            s_d.shadow[CH_EXT1] = s_q.frac[CH_EXT1];
         end else if (reg_addr == EXT2_INTEGER_ADDR) begin
            s_d.rdata = s_q.integ[CH_EXT2];
            s_d.shadow[CH_EXT2] = s_q.frac[CH_EXT2];
         end else if (reg_addr == EXT3_INTEGER_ADDR) begin
            s_d.rdata = s_q.integ[CH_EXT3];
            s_d.shadow[CH_EXT3] = s_q.frac[CH_EXT3];
         end else if (reg_addr == INT_FRAC_ADDR) begin
            s_d.rdata = frac_byte(s_q.shadow[CH_INT]);
         end else if (reg_addr == EXT1_FRAC_ADDR) begin
            s_d.rdata = frac_byte(s_q.shadow[CH_EXT1]);
         end else if (reg_addr == EXT2_FRAC_ADDR) begin
            s_d.rdata = frac_byte(s_q.shadow[CH_EXT2]);
         end else if (reg_addr == EXT3_FRAC_ADDR) begin
            s_d.rdata = frac_byte(s_q.shadow[CH_EXT3]);
         end else if (reg_addr == STATUS_ADDR) begin
            s_d.rdata = s_q.status;
            status_rd = 1'b1;
         end else if (is_config(reg_addr)) begin
            s_d.rdata = s_q.cfg;
         end else if (is_rate(reg_addr)) begin
            s_d.rdata = s_q.rate & RATE_WR_MASK;
         end else begin
            s_d.rdata = READ_ZERO;
         end
      end

      // Busy follows the converter live
      s_d.status[BUSY_BIT] = adc_busy;

      // Latched flags: a condition in the read cycle wins over the clear
      s_d.status[INT_HIGH_BIT] = int_high_cond ||
         (s_q.status[INT_HIGH_BIT] && !status_rd);
      s_d.status[INT_LOW_BIT] = int_low_cond ||
         (s_q.status[INT_LOW_BIT] && !status_rd);
      s_d.status[EXT_HIGH_BIT] = ext_high_cond ||
         (s_q.status[EXT_HIGH_BIT] && !status_rd);
      s_d.status[EXT_LOW_BIT] = ext_low_cond ||
         (s_q.status[EXT_LOW_BIT] && !status_rd);
      s_d.status[FAULT_BIT] = diode_fault_cond ||
         (s_q.status[FAULT_BIT] && !status_rd);

      // Over-temperature output and its self-clearing flags
      therm_d = ext_therm_cond || int_therm_cond;
      s_d.therm = therm_d;
      s_d.status[EXT_THERM_BIT] = ext_therm_cond ||
         (s_q.status[EXT_THERM_BIT] && therm_d);
      s_d.status[INT_THERM_BIT] = int_therm_cond ||
         (s_q.status[INT_THERM_BIT] && therm_d);

      // Alert from flags 6..2 only; busy never contributes
      alert_flags = s_d.status[INT_HIGH_BIT:FAULT_BIT];
      if (s_q.cfg[COMPARATOR_BIT]) begin
         s_d.alert = |alert_flags;
      end else begin
         s_d.alert = (|alert_flags) && !s_q.cfg[MASK_ALL_BIT];
      end

      // Operating state; sleep overrides standby select
      case (1'b1)
         s_q.rate[SLEEP_BIT]:  s_d.mode = MODE_SLEEP;
         s_q.cfg[STANDBY_BIT]: s_d.mode = MODE_STANDBY;
         default:              s_d.mode = MODE_ACTIVE;
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q         <= '0;
         s_q.cfg     <= CONFIG_RESET;
         s_q.rate    <= RATE_RESET;
         s_q.status  <= STATUS_RESET;
         s_q.mode    <= MODE_ACTIVE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs, all from flops
   assign reg_rdata                 = s_q.rdata;
   assign alert_out                 = s_q.alert;
   assign therm_out                 = s_q.therm;
   assign single_conversion_trigger = s_q.trigger;
   assign conversion_enable         = (s_q.mode == MODE_ACTIVE);
   assign standby_mode              = (s_q.mode == MODE_STANDBY);
   assign sleep_mode                = (s_q.mode == MODE_SLEEP);
   assign resistance_corr_off_ch1   = s_q.cfg[CORR_OFF1_BIT];
   assign resistance_corr_off_ch23  = s_q.cfg[CORR_OFF23_BIT];
   assign range_extended            = s_q.cfg[RANGE_BIT];
   assign averaging_disable         = s_q.cfg[AVG_OFF_BIT];
   assign antiparallel_disable      = s_q.cfg[APD_OFF_BIT];
   assign rate_code                 = s_q.rate[3:0];

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_LOW_BYTE_ZERO: assert property (
      reg_rd && (reg_addr == INT_FRAC_ADDR || reg_addr == EXT1_FRAC_ADDR)
      |=> reg_rdata[4:0] == 5'h00)
      else $error("low result byte has bits 4..0 set");

   AST_RATE_GAP_ZERO: assert property (
      reg_rd && is_rate(reg_addr) |=> reg_rdata[6:4] == 3'h0)
      else $error("rate register bits 6..4 not zero");

   AST_SHADOW_HOLDS: assert property (
      reg_rd && reg_addr == EXT1_INTEGER_ADDR ##1
      (!(reg_rd && reg_addr == EXT1_INTEGER_ADDR)) [*2] ##0
      (reg_rd && reg_addr == EXT1_FRAC_ADDR)
      |=> reg_rdata[7:5] == $past(s_q.frac[CH_EXT1], 3))
      else $error("low byte does not match last high-byte read");

   AST_BUSY_FLAG: assert property (
      adc_busy |=> s_q.status[BUSY_BIT])
      else $error("busy flag does not follow converter");

   AST_INT_HIGH_ALERT: assert property (
      int_high_cond && !s_q.cfg[MASK_ALL_BIT] && !s_q.cfg[COMPARATOR_BIT]
      |=> alert_out)
      else $error("internal high did not raise alert");

   AST_FAULT_HELD: assert property (
      diode_fault_cond ##1 (!(reg_rd && reg_addr == STATUS_ADDR)) [*3]
      |-> s_q.status[FAULT_BIT])
      else $error("fault flag lost without a status read");

   AST_FLAG_CLEARS: assert property (
      reg_rd && reg_addr == STATUS_ADDR && !ext_low_cond
      |=> !s_q.status[EXT_LOW_BIT])
      else $error("external low flag not cleared by read");

   AST_THERM_SELF_CLEAR: assert property (
      $fell(therm_out) |-> !s_q.status[EXT_THERM_BIT] &&
      !s_q.status[INT_THERM_BIT])
      else $error("over-temperature flag outlived the output");

   AST_MASK_BLOCKS: assert property (
      s_q.cfg[MASK_ALL_BIT] && !s_q.cfg[COMPARATOR_BIT] |=> !alert_out)
      else $error("alert asserted while masked");

   AST_SLEEP_WINS: assert property (
      reg_wr && is_rate(reg_addr) && reg_wdata[SLEEP_BIT]
      ##1 !(reg_wr && is_rate(reg_addr)) |=> sleep_mode)
      else $error("sleep bit did not override");

   AST_ONE_SHOT_ACTIVE: assert property (
      reg_wr && reg_addr == ONE_SHOT_ADDR && !standby_mode
      |=> !single_conversion_trigger)
      else $error("one-shot accepted outside standby");

   AST_CONFIG_ALIAS: assert property (
      reg_wr && reg_addr == CONFIG_ALIAS_ADDR ##1 !reg_wr ##1
      reg_rd && reg_addr == CONFIG_ADDR && !reg_wr
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("configuration alias mismatch");

   COV_ONE_SHOT: cover property (single_conversion_trigger);
   COV_THERM_CYCLE: cover property ($rose(therm_out) ##[1:20] $fell(therm_out));
   COV_ALERT_COMPARATOR: cover property (alert_out && s_q.cfg[COMPARATOR_BIT]);

endmodule

/* common/temp_regs_pkg.sv */
// Register map, field positions and reset values of the temperature
// monitor result, status and configuration registers.
// Assumes a byte-wide register port from a two-wire bus protocol engine.
package temp_regs_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;
   typedef logic [1:0] chan_t;
   typedef logic [2:0] frac_t;

   // ==========================================================
   // Register offsets
   localparam addr_t INT_INTEGER_ADDR  = 8'h00;
   localparam addr_t EXT1_INTEGER_ADDR = 8'h01;
   localparam addr_t STATUS_ADDR       = 8'h02;
   localparam addr_t CONFIG_ADDR       = 8'h03;
   localparam addr_t RATE_ADDR         = 8'h04;
   localparam addr_t CONFIG_ALIAS_ADDR = 8'h09;
   localparam addr_t RATE_ALIAS_ADDR   = 8'h0A;
   localparam addr_t ONE_SHOT_ADDR     = 8'h0F;
   localparam addr_t EXT1_FRAC_ADDR    = 8'h10;
   localparam addr_t EXT2_INTEGER_ADDR = 8'h23;
   localparam addr_t EXT2_FRAC_ADDR    = 8'h24;
   localparam addr_t INT_FRAC_ADDR     = 8'h29;
   localparam addr_t EXT3_INTEGER_ADDR = 8'h2A;
   localparam addr_t EXT3_FRAC_ADDR    = 8'h2B;

   // ==========================================================
   // Status bit positions
   localparam int BUSY_BIT       = 7;
   localparam int INT_HIGH_BIT   = 6;
   localparam int INT_LOW_BIT    = 5;
   localparam int EXT_HIGH_BIT   = 4;
   localparam int EXT_LOW_BIT    = 3;
   localparam int FAULT_BIT      = 2;
   localparam int EXT_THERM_BIT  = 1;
   localparam int INT_THERM_BIT  = 0;

   // ==========================================================
   // Configuration bit positions
   localparam int MASK_ALL_BIT   = 7;
   localparam int STANDBY_BIT    = 6;
   localparam int COMPARATOR_BIT = 5;
   localparam int CORR_OFF1_BIT  = 4;
   localparam int CORR_OFF23_BIT = 3;
   localparam int RANGE_BIT      = 2;
   localparam int AVG_OFF_BIT    = 1;
   localparam int APD_OFF_BIT    = 0;

   // ==========================================================
   // Conversion rate register layout, fraction position, reset and read-zero values
   localparam int    SLEEP_BIT      = 7;
   localparam int    FRAC_LSB       = 5;
   localparam byte_t RATE_WR_MASK   = 8'h8F;
   localparam byte_t RATE_RESET     = 8'h06;
   localparam byte_t CONFIG_RESET   = 8'h00;
   localparam byte_t STATUS_RESET   = 8'h00;
   localparam byte_t READ_ZERO      = 8'h00;

   // Channel indices
   localparam chan_t CH_INT  = 2'd0;
   localparam chan_t CH_EXT1 = 2'd1;
   localparam chan_t CH_EXT2 = 2'd2;
   localparam chan_t CH_EXT3 = 2'd3;

   // Operating state, one-hot
   typedef enum logic [2:0] {
      MODE_ACTIVE  = 3'b001,
      MODE_STANDBY = 3'b010,
      MODE_SLEEP   = 3'b100
   } op_mode_t;

endpackage

/* verification/converter_model.sv */
// Converter stand-in: runs conversion cycles and posts channel results.
// Assumes the register block's enable and one-shot outputs drive it.
`timescale 1ns/100ps
module converter_model (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 conversion_enable,
   input  wire logic                 single_conversion_trigger,
   input  wire logic [3:0][7:0]      chan_integer,
   input  wire logic [3:0][2:0]      chan_fraction,
   output logic                      adc_busy,
   output logic                      result_valid,
   output temp_regs_pkg::chan_t      result_channel,
   output temp_regs_pkg::byte_t      result_integer,
   output temp_regs_pkg::frac_t      result_fraction
);
   import temp_regs_pkg::*;
   logic [4:0] cnt_q;
   chan_t      ch_w;
   assign ch_w = chan_t'(5'h04 - cnt_q);
   // ==========================================================
   // Sequencer: 12 busy cycles, one result per channel in the last four
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q           <= 5'h00;
         adc_busy        <= 1'b0;
         result_valid    <= 1'b0;
         result_channel  <= CH_INT;
         result_integer  <= 8'h00;
         result_fraction <= 3'h0;
      end else begin
         result_valid    <= 1'b0;
         // Idle data inverts so a stale value never looks valid
         result_integer  <= ~result_integer;
         result_fraction <= ~result_fraction;
         if (cnt_q != 5'h00) begin
            cnt_q    <= cnt_q - 5'h01;
            adc_busy <= (cnt_q != 5'h01);
            if (cnt_q <= 5'h04) begin
               result_valid    <= 1'b1;
               result_channel  <= ch_w;
               result_integer  <= chan_integer[ch_w];
               result_fraction <= chan_fraction[ch_w];
            end
         end else if (conversion_enable || single_conversion_trigger) begin
            cnt_q    <= 5'h0C;
            adc_busy <= 1'b1;
         end
      end
   end
endmodule

/* verification/temp_monitor_status_config_regs_bench.sv */
// Self-checking bench for the monitor register block.
// Assumes the converter model file and the register package.
`timescale 1ns/100ps
module temp_monitor_status_config_regs_bench;
   import temp_regs_pkg::*;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   addr_t           reg_addr = 8'h00;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   byte_t           reg_wdata = 8'h00;
   logic [7:0]      reg_rdata;
   logic            busy, valid, alert, therm, rate_code_en, trig, stby, slp;
   logic            rc1, rc23, rng, avg, apd;
   chan_t           r_ch;
   byte_t           r_int;
   frac_t           r_frac;
   logic [3:0]      rate;
   logic [4:0]      cond_v = 5'h00;
   logic [1:0]      therm_v = 2'h0;
   logic [3:0][7:0] ch_int = '0;
   logic [3:0][2:0] ch_frac = '0;
   int              error_cnt = 0;
   int              num_checks = 0;
   int              trig_cnt = 0;
   int              p, c, k, t0;
   byte_t           rd, v;
   byte_t int_tab [2][4] = '{'{8'h00, 8'h19, 8'hF6, 8'h7F},
                             '{8'h00, 8'h80, 8'h01, 8'h55}};
   frac_t frac_tab [2][4] = '{'{3'h7, 3'h1, 3'h2, 3'h3},
                              '{3'h4, 3'h5, 3'h6, 3'h0}};
   addr_t hi_a [4] = '{INT_INTEGER_ADDR, EXT1_INTEGER_ADDR,
                       EXT2_INTEGER_ADDR, EXT3_INTEGER_ADDR};
   addr_t lo_a [4] = '{INT_FRAC_ADDR, EXT1_FRAC_ADDR,
                       EXT2_FRAC_ADDR, EXT3_FRAC_ADDR};

   temp_monitor_regs temp_monitor_regs_i (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .adc_busy(busy), .result_valid(valid), .result_channel(r_ch),
      .result_integer(r_int), .result_fraction(r_frac),
      .int_high_cond(cond_v[4]), .int_low_cond(cond_v[3]),
      .ext_high_cond(cond_v[2]), .ext_low_cond(cond_v[1]),
      .diode_fault_cond(cond_v[0]), .ext_therm_cond(therm_v[1]),
      .int_therm_cond(therm_v[0]), .alert_out(alert), .therm_out(therm),
      .conversion_enable(rate_code_en), .single_conversion_trigger(trig),
      .standby_mode(stby), .sleep_mode(slp),
      .resistance_corr_off_ch1(rc1), .resistance_corr_off_ch23(rc23),
      .range_extended(rng), .averaging_disable(avg),
      .antiparallel_disable(apd), .rate_code(rate));
   converter_model converter_model_i (
      .clk(clk), .reset_n(reset_n), .conversion_enable(rate_code_en),
      .single_conversion_trigger(trig), .chan_integer(ch_int),
      .chan_fraction(ch_frac), .adc_busy(busy), .result_valid(valid),
      .result_channel(r_ch), .result_integer(r_int),
      .result_fraction(r_frac));

   // ==========================================================
   // Clock, trigger pulse counter, watchdog
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (trig === 1'b1) trig_cnt++;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("Error watchdog expired");
      wrap_up();
   end

   // ==========================================================
   // Register port tasks and comparisons
   task automatic reg_write(input addr_t a, input byte_t d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic reg_read(input addr_t a, output byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk8(input string nm, input byte_t e, input byte_t g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic rd_chk(input string nm, input addr_t a, input byte_t e);
      byte_t d;
      reg_read(a, d);
      chk8(nm, e, d);
   endtask
   // Bounded waits; a stuck converter shows up as a mismatch
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (busy !== 1'b0 && n < 60);
      chk1("idle", 1'b0, busy);
   endtask
   task automatic wait_rate_code();
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (!(valid === 1'b1 && r_ch === CH_EXT3) && n < 40);
      end
   endtask
   task automatic pulse_cond(input logic [4:0] b);
      @(posedge clk);
      cond_v <= b;
      @(posedge clk);
      cond_v <= 5'h00;
      @(posedge clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1 chk8("rate code", RATE_RESET, {4'h0, rate});
      rd_chk("config", CONFIG_ADDR, CONFIG_RESET);
      rd_chk("rate", RATE_ALIAS_ADDR, RATE_RESET);
      rd_chk("unmapped", 8'h50, READ_ZERO);
      $display("test reset done");
      // Two passes cover all eight fraction codes; shadow held across
      for (p = 0; p < 2; p++) begin
         for (c = 0; c < 4; c++) begin
            ch_int[c]  <= int_tab[p][c];
            ch_frac[c] <= frac_tab[p][c];
         end
         wait_rate_code();
         if (p == 1) rd_chk("shadow", EXT1_FRAC_ADDR, 8'h20);
         for (c = 0; c < 4; c++) begin
            reg_read(hi_a[c], rd);
            chk8("integer", int_tab[p][c], rd);
            v = {frac_tab[p][c], 5'h00};
            rd_chk("fraction", lo_a[c], v);
         end
         reg_read(EXT1_INTEGER_ADDR, rd);
      end
      $display("test results done");
      for (k = 0; k < 2; k++) begin
         v = k ? 8'hA5 : 8'h5A;
         reg_write(k ? CONFIG_ALIAS_ADDR : CONFIG_ADDR, v);
         rd_chk("alias", k ? CONFIG_ADDR : CONFIG_ALIAS_ADDR, v);
         rd = {1'b0, stby, 1'b0, rc1, rc23, rng, avg, apd};
         chk8("config outs", v & 8'h5F, rd);
         chk1("active", ~v[STANDBY_BIT], rate_code_en);
      end
      reg_write(RATE_ADDR, 8'hFF);
      rd_chk("rate alias", RATE_ALIAS_ADDR, 8'h8F);
      chk8("sleep outs", 8'h8F, {slp, rate_code_en, stby, 1'b0, rate});
      reg_write(RATE_ALIAS_ADDR, 8'h03);
      rd_chk("rate", RATE_ADDR, 8'h03);
      chk8("awake outs", 8'h43, {slp, rate_code_en, stby, 1'b0, rate});
      $display("test config done");
      reg_write(CONFIG_ADDR, 8'h40);
      wait_idle();
      t0 = trig_cnt;
      reg_write(ONE_SHOT_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk8("one-shot", byte_t'(t0 + 1), byte_t'(trig_cnt));
      reg_write(ONE_SHOT_ADDR, 8'h01);
      rd_chk("busy status", STATUS_ADDR, 8'h80);
      chk1("busy alert", 1'b0, alert);
      wait_idle();
      reg_write(CONFIG_ADDR, 8'h00);
      reg_write(ONE_SHOT_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk8("refused", byte_t'(t0 + 1), byte_t'(trig_cnt));
      reg_write(CONFIG_ADDR, 8'h40);
      wait_idle();
      $display("test one-shot done");
      for (k = 0; k < 5; k++) begin
         pulse_cond(5'h10 >> k);
         chk1("alert", 1'b1, alert);
         rd_chk("flag", STATUS_ADDR, 8'h40 >> k);
         rd_chk("cleared", STATUS_ADDR, 8'h00);
         chk1("alert off", 1'b0, alert);
      end
      reg_write(CONFIG_ADDR, 8'hC0);
      pulse_cond(5'h04);
      chk1("masked alert", 1'b0, alert);
      rd_chk("masked flag", STATUS_ADDR, 8'h10);
      reg_write(CONFIG_ADDR, 8'hE0);
      pulse_cond(5'h01);
      chk1("comparator alert", 1'b1, alert);
      rd_chk("fault flag", STATUS_ADDR, 8'h04);
      chk1("comparator off", 1'b0, alert);
      $display("test flags done");
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         therm_v <= 2'h1 << k;
         repeat (2) @(posedge clk);
         #1 chk1("therm", 1'b1, therm);
         rd_chk("therm flag", STATUS_ADDR, 8'h01 << k);
         rd_chk("therm held", STATUS_ADDR, 8'h01 << k);
         @(posedge clk);
         therm_v <= 2'h0;
         repeat (2) @(posedge clk);
         #1 chk1("therm off", 1'b0, therm);
         rd_chk("therm gone", STATUS_ADDR, 8'h00);
      end
      $display("test therm done");
      wrap_up();
   end
endmodule
